// ===== include/sbcr_pkg.sv
// Function
// - A command is 16 bits: 7-bit address, access bit, data byte.
// - Access bit clear reads the register; set writes the data byte.
// - Data bits D0..D7 sit in frame bits 8..15; whole-word access.
// - Reserved bits read zero; master writes zero there.
// - Only hardware-modifiable bits change without a master write.
// - Mode/supply is zero after power-on or soft reset; restart keeps 5,1,0.
// - Mode field: normal, sleep, stop, or 11 for soft reset.
// - A stop-to-sleep request over the command port is refused.
// - Restart forces normal mode; restart or overheat turns regulator 2 off.
// - Bit 5 turns the third regulator off or on independently.
// - Regulator 2 policy: off, normal, normal and stop, all but fail-safe.
// - Overvoltage always flagged; bit 2 adds a restart/fail-safe request.
// - Bits 1:0 pick one of four main reset thresholds, 00 highest.
// - A write frame returns the content held before that write.
// - Hardware control keeps 7,3 on soft reset; restart clears 5,2,1.
// - Bit 7 picks main voltage or lower alternative for regulator 3.
// - Bit 6 clear pulls the reset output low on soft reset.
// - Bit 5 set drives failure outputs; clear leaves them to failures.
// - A failure keeps outputs active until the failure flag clears.
// - Bit 4 clear drops regulator 3 on supply undervoltage.
// - Bit 3 picks stand-alone or load share; bit 1 shares in stop.
// - Bit 0 picks first (1) or second (0) watchdog failure reaction.
// Package: constants and types of the mode/supply register bank.
// Assumes a single 200 MHz clock domain around the bank.
package sbcr_pkg;
    localparam logic [4:0] SBCR_FRAME_BITS = 5'h10;
    localparam logic [4:0] SBCR_ADDR_LAST = 5'h07;
    localparam int SBCR_RW_BIT = 7;
    localparam logic [6:0] SBCR_ADDR_MSC = 7'h01;
    localparam logic [6:0] SBCR_ADDR_HWC = 7'h02;
    localparam logic [7:0] SBCR_MSC_POR = 8'h00;
    localparam logic [7:0] SBCR_MSC_RESTART_KEEP = 8'h23;
    localparam logic [7:0] SBCR_HWC_POR = 8'h00;
    localparam logic [7:0] SBCR_HWC_SOFT_KEEP = 8'h88;
    localparam logic [7:0] SBCR_HWC_RESTART_KEEP = 8'hd9;
    localparam logic [7:0] SBCR_HWC_WMASK = 8'hfb;
    localparam logic [1:0] SBCR_PIN_IDLE_HI = 2'h3;
    localparam logic [1:0] SBCR_MODE_NORMAL = 2'h0;
    localparam logic [1:0] SBCR_MODE_SLEEP = 2'h1;
    localparam logic [1:0] SBCR_MODE_STOP = 2'h2;
    localparam logic [1:0] SBCR_MODE_SOFTRST = 2'h3;
    localparam logic [1:0] SBCR_REG2_OFF = 2'h0;
    localparam logic [1:0] SBCR_REG2_NORM = 2'h1;
    localparam logic [1:0] SBCR_REG2_NORM_STOP = 2'h2;

    typedef enum logic [1:0] {
        SBCR_DEV_NORMAL, SBCR_DEV_SLEEP, SBCR_DEV_STOP, SBCR_DEV_FAILSAFE
    } sbcr_dev_mode_e;
    typedef enum logic {SBCR_SPI_IDLE, SBCR_SPI_SHIFT} sbcr_spi_e;

    // Mode and supply control, bit 7 first
    typedef struct packed {
        logic [1:0] mode;
        logic third_regulator_enable;
        logic [1:0] second_regulator_policy;
        logic main_overvoltage_reaction;
        logic [1:0] main_reset_threshold;
    } sbcr_msc_s;

    // Hardware control, bit 7 first
    typedef struct packed {
        logic third_regulator_voltage_select;
        logic soft_reset_output_suppress;
        logic failure_output_sw_activate;
        logic third_regulator_undervoltage_keep;
        logic third_regulator_load_share;
        logic reserved;
        logic load_share_in_stop;
        logic watchdog_first_fail;
    } sbcr_hwc_s;

    // Whole state of the bank
    typedef struct packed {
        logic [1:0] cs_sync;
        logic [1:0] sck_sync;
        logic [1:0] mosi_sync;
        logic [1:0] uv_sync;
        logic sck_prev;
        sbcr_spi_e st;
        logic [4:0] cnt;
        logic [15:0] rx;
        logic [7:0] rdata;
        sbcr_msc_s msc;
        sbcr_hwc_s hwc;
        logic miso;
        logic miso_oe;
        logic fo;
        logic soft_rst;
        logic ro_low;
        logic ov_flag;
        logic ov_react;
        logic reg3_on;
        logic reg2_on;
        logic ls_on;
    } sbcr_state_s;
endpackage

// ===== rtl/sbcr_regs.sv
// Mode/supply and hardware control registers behind the 16-bit
// serial command port. Assumes pins arrive asynchronously and that
// the state machine inputs come from logic on clk_i.
// Frames are taken LSB first on rising serial clock edges; the serial
// clock phases must each last a few clk_i cycles to survive the sync.
`timescale 1ns/1ps
module sbcr_regs (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Serial command pins
    input wire logic spi_cs_b_i,
    input wire logic spi_sck_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    output logic spi_miso_oe_o,
    // Device state and events, same clock
    input wire sbcr_pkg::sbcr_dev_mode_e device_mode_i,
    input wire logic restart_entry_i,
    input wire logic overtemp_i,
    input wire logic main_ov_i,
    input wire logic failure_active_i,
    // Supply undervoltage pin
    input wire logic supply_uv_i,
    // Register contents
    output sbcr_pkg::sbcr_msc_s msc_o,
    output sbcr_pkg::sbcr_hwc_s hwc_o,
    // Derived controls
    output logic soft_reset_o,
    output logic reset_output_pin_low_o,
    output logic failure_output_pins_o,
    output logic main_ov_flag_o,
    output logic main_ov_mode_req_o,
    output logic third_regulator_on_o,
    output logic second_regulator_on_o,
    output logic load_share_on_o
);
    sbcr_pkg::sbcr_state_s s;
    sbcr_pkg::sbcr_state_s next_s;
    logic cs_b;
    logic sck_rise;
    logic frame_end;
    logic is_write;
    logic [6:0] addr;
    logic [7:0] wdata;

    // Synchronised pin views and decoded frame fields
    assign cs_b = s.cs_sync[1];
    assign sck_rise = s.sck_sync[1] & ~s.sck_prev;
    assign frame_end = (s.st == sbcr_pkg::SBCR_SPI_SHIFT) & cs_b
        & (s.cnt == sbcr_pkg::SBCR_FRAME_BITS);
    assign addr = s.rx[6:0];
    assign is_write = s.rx[sbcr_pkg::SBCR_RW_BIT];
    assign wdata = s.rx[15:8];

    // Readback mux; unmapped addresses answer zero
    function automatic logic [7:0] rd_mux(input logic [6:0] a,
            input sbcr_pkg::sbcr_state_s st);
        logic [7:0] r;
        r = 8'h00;
        if (a == sbcr_pkg::SBCR_ADDR_MSC) begin
            r = st.msc;
        end else if (a == sbcr_pkg::SBCR_ADDR_HWC) begin
            r = st.hwc & sbcr_pkg::SBCR_HWC_WMASK;
        end
        return r;
    endfunction

    // Next-state logic: serial shifter, then register updates
    always_comb begin
        sbcr_pkg::sbcr_msc_s v;
        logic [7:0] rd;
        logic uv;
        next_s = s;
        v = s.msc;
        rd = rd_mux(addr, s);
        uv = s.uv_sync[1];
        // Second flop only reads the first
        next_s.cs_sync = {s.cs_sync[0], spi_cs_b_i};
        next_s.sck_sync = {s.sck_sync[0], spi_sck_i};
        next_s.mosi_sync = {s.mosi_sync[0], spi_mosi_i};
        next_s.uv_sync = {s.uv_sync[0], supply_uv_i};
        next_s.sck_prev = s.sck_sync[1];
        next_s.soft_rst = 1'b0;
        next_s.ro_low = 1'b0;
        next_s.miso_oe = ~cs_b;
        case (s.st)
            sbcr_pkg::SBCR_SPI_IDLE: begin
                next_s.miso = 1'b0;
                if (!cs_b) begin
                    next_s.st = sbcr_pkg::SBCR_SPI_SHIFT;
                    next_s.cnt = 5'h00;
                end
            end
            sbcr_pkg::SBCR_SPI_SHIFT: begin
                if (cs_b) begin
                    next_s.st = sbcr_pkg::SBCR_SPI_IDLE;
                    next_s.miso = 1'b0;
                end else if (sck_rise &&
                        s.cnt != sbcr_pkg::SBCR_FRAME_BITS) begin
                    next_s.rx[s.cnt[3:0]] = s.mosi_sync[1];
                    next_s.cnt = s.cnt + 5'h01;
                    // Old content latched before any write lands
                    if (s.cnt == sbcr_pkg::SBCR_ADDR_LAST) begin
                        next_s.miso = rd[0];
                        next_s.rdata = {1'b0, rd[7:1]};
                    end else if (s.cnt > sbcr_pkg::SBCR_ADDR_LAST) begin
                        next_s.miso = s.rdata[0];
                        next_s.rdata = {1'b0, s.rdata[7:1]};
                    end else begin
                        next_s.miso = 1'b0;
                    end
                end
            end
            default: begin
                next_s.st = sbcr_pkg::SBCR_SPI_IDLE;
            end
        endcase

        // Master writes; short frames are dropped, bits past the 16th are ignored
        if (frame_end && is_write) begin
            if (addr == sbcr_pkg::SBCR_ADDR_MSC) begin
                v = wdata;
                if (v.mode == sbcr_pkg::SBCR_MODE_SOFTRST) begin
                    next_s.msc = sbcr_pkg::SBCR_MSC_POR;
                    // Bits 7 and 3 survive; reset output follows bit 6
                    next_s.hwc = s.hwc
                        & sbcr_pkg::SBCR_HWC_SOFT_KEEP;
                    next_s.soft_rst = 1'b1;
                    next_s.ro_low =
                        ~s.hwc.soft_reset_output_suppress;
                end else begin
                    if (device_mode_i == sbcr_pkg::SBCR_DEV_STOP &&
                            v.mode == sbcr_pkg::SBCR_MODE_SLEEP) begin
                        v.mode = s.msc.mode;
                    end
                    next_s.msc = v;
                end
            end else if (addr == sbcr_pkg::SBCR_ADDR_HWC) begin
                next_s.hwc = wdata & sbcr_pkg::SBCR_HWC_WMASK;
            end
        end

        // Hardware changes win over a write in the same cycle
        if (overtemp_i) begin
            next_s.msc.second_regulator_policy =
                sbcr_pkg::SBCR_REG2_OFF;
        end
        if (restart_entry_i) begin
            // Clearing bits 7:6 and 4:3 forces normal mode, reg 2 off
            next_s.msc = next_s.msc
                & sbcr_pkg::SBCR_MSC_RESTART_KEEP;
            // Mask also drops the software failure-output bit
            next_s.hwc = next_s.hwc
                & sbcr_pkg::SBCR_HWC_RESTART_KEEP;
        end

        // Derived controls follow the registered fields
        next_s.ov_flag = main_ov_i;
        next_s.ov_react = main_ov_i
            & next_s.msc.main_overvoltage_reaction;
        // Software bit only adds; a live failure holds the outputs
        next_s.fo = next_s.hwc.failure_output_sw_activate
            | failure_active_i;
        // Undervoltage drops regulator 3 unless the keep bit is set
        next_s.reg3_on = next_s.msc.third_regulator_enable
            & (~uv
            | next_s.hwc.third_regulator_undervoltage_keep);
        case (next_s.msc.second_regulator_policy)
            sbcr_pkg::SBCR_REG2_OFF: next_s.reg2_on = 1'b0;
            sbcr_pkg::SBCR_REG2_NORM:
                next_s.reg2_on = device_mode_i == sbcr_pkg::SBCR_DEV_NORMAL;
            sbcr_pkg::SBCR_REG2_NORM_STOP:
                next_s.reg2_on = device_mode_i == sbcr_pkg::SBCR_DEV_NORMAL
                    || device_mode_i == sbcr_pkg::SBCR_DEV_STOP;
            default:
                next_s.reg2_on =
                    device_mode_i != sbcr_pkg::SBCR_DEV_FAILSAFE;
        endcase
        next_s.ls_on = next_s.hwc.third_regulator_load_share
            & (device_mode_i != sbcr_pkg::SBCR_DEV_STOP
            | next_s.hwc.load_share_in_stop);
    end

    // State register; pins reset to their idle level
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s <= '0;
            s.cs_sync <= sbcr_pkg::SBCR_PIN_IDLE_HI;
        end else begin
            s <= next_s;
        end
    end

    // All outputs straight from flops
    assign spi_miso_o = s.miso;
    assign spi_miso_oe_o = s.miso_oe;
    assign msc_o = s.msc;
    assign hwc_o = s.hwc;
    assign soft_reset_o = s.soft_rst;
    assign reset_output_pin_low_o = s.ro_low;
    assign failure_output_pins_o = s.fo;
    assign main_ov_flag_o = s.ov_flag;
    assign main_ov_mode_req_o = s.ov_react;
    assign third_regulator_on_o = s.reg3_on;
    assign second_regulator_on_o = s.reg2_on;
    assign load_share_on_o = s.ls_on;

    // Checks of the register rules; hardware events are excluded where a
    // rule only speaks of master traffic, since they win over a write
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    // Cycle free of restart and overheat forcing
    sequence quiet_hw;
        !restart_entry_i && !overtemp_i;
    endsequence
    // Complete write frame to one address
    sequence write_to(logic [6:0] a);
        frame_end && is_write && addr == a;
    endsequence

    // Reserved bit is never stored
    a_reserved_zero: assert property (
            s.hwc.reserved == 1'b0)
        else $error("reserved bit set");

    // Frame ended short of 16 bits leaves both registers alone
    a_bad_frame: assert property (
            (s.st == sbcr_pkg::SBCR_SPI_SHIFT && cs_b
            && s.cnt != sbcr_pkg::SBCR_FRAME_BITS) and quiet_hw
            |=> $stable(s.msc) && $stable(s.hwc))
        else $error("short frame changed a register");

    // Read frame changes nothing
    a_read_only: assert property (
            (frame_end && !is_write) and quiet_hw
            |=> $stable(s.msc) && $stable(s.hwc))
        else $error("read frame changed a register");

    // Data byte lands in the hardware control register
    a_hwc_write: assert property (
            write_to(sbcr_pkg::SBCR_ADDR_HWC) and quiet_hw
            |=> s.hwc == ($past(wdata) & sbcr_pkg::SBCR_HWC_WMASK))
        else $error("write data not stored");

    // Without a frame or event the registers hold
    a_no_self_change: assert property (
            !frame_end and quiet_hw
            |=> $stable(s.msc) && $stable(s.hwc))
        else $error("register changed without cause");

    // Restart keeps only the listed bits
    a_restart_keep: assert property (
            restart_entry_i && !frame_end
            |=> s.msc == ($past(s.msc) & sbcr_pkg::SBCR_MSC_RESTART_KEEP)
            && s.hwc == ($past(s.hwc) & sbcr_pkg::SBCR_HWC_RESTART_KEEP))
        else $error("restart values wrong");

    // Soft reset command: one pulse, cleared register, gated reset pin
    a_soft_reset: assert property (
            write_to(sbcr_pkg::SBCR_ADDR_MSC)
            and (wdata[7:6] == sbcr_pkg::SBCR_MODE_SOFTRST) and quiet_hw
            |=> soft_reset_o && s.msc == sbcr_pkg::SBCR_MSC_POR
            && reset_output_pin_low_o
            == !$past(s.hwc.soft_reset_output_suppress)
            ##1 !soft_reset_o)
        else $error("soft reset not one pulse");

    // Sleep request while stopped keeps the mode field
    a_stop_no_sleep: assert property (
            write_to(sbcr_pkg::SBCR_ADDR_MSC)
            and (device_mode_i == sbcr_pkg::SBCR_DEV_STOP
            && wdata[7:6] == sbcr_pkg::SBCR_MODE_SLEEP) and quiet_hw
            |=> $stable(s.msc.mode))
        else $error("stop to sleep accepted");

    // Restart or overheat leaves the regulator 2 field off
    a_restart_force: assert property (
            restart_entry_i || overtemp_i
            |=> s.msc.second_regulator_policy == sbcr_pkg::SBCR_REG2_OFF)
        else $error("regulator 2 field not off");

    // First data bit out is the content before this frame
    a_old_readback: assert property (
            s.st == sbcr_pkg::SBCR_SPI_SHIFT && !cs_b && sck_rise
            && s.cnt == sbcr_pkg::SBCR_ADDR_LAST
            && addr == sbcr_pkg::SBCR_ADDR_MSC
            |=> spi_miso_o == $past(s.msc[0]))
        else $error("readback not old content");

    // A live failure keeps the outputs on whatever the software bit says
    a_failure_hold: assert property (
            failure_active_i |=> failure_output_pins_o)
        else $error("failure outputs released");

    // Undervoltage without the keep bit turns regulator 3 off next cycle
    a_uv_drop: assert property (
            s.uv_sync[1] && !next_s.hwc.third_regulator_undervoltage_keep
            |=> !third_regulator_on_o)
        else $error("regulator 3 kept on at undervoltage");
endmodule // sbcr_regs

// ===== verif/sbcr_spi_master.sv
// Host microcontroller model acting as master on the serial command port.
// Assumes the bench calls xfer from one process; pins move on clk_i edges.
`timescale 1ns/1ps
module sbcr_spi_master (
    // Clock
    input wire logic clk_i,
    // Serial pins
    input wire logic miso_i,
    output logic cs_b_o,
    output logic sck_o,
    output logic mosi_o
);
    // Idle pins: select high, serial clock still and low
    initial begin
        cs_b_o = 1'b1;
        sck_o = 1'b0;
        mosi_o = 1'b1;
    end

    // One frame of n bits, LSB first; each sck phase lasts 5 clk so the
    // slave's two-flop synchroniser cannot miss an edge
    task automatic xfer(input logic [6:0] addr, input logic wr,
                        input logic [7:0] data, input int n,
                        output logic [7:0] rd);
        logic [15:0] f;
        f = {data, wr, addr};
        rd = 8'h00;
        @(posedge clk_i) cs_b_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            mosi_o <= f[i];
            repeat (5) @(posedge clk_i);
            if (i >= 8) rd[i-8] = miso_i; // Read byte D0 first
            sck_o <= 1'b1;
            repeat (5) @(posedge clk_i);
            sck_o <= 1'b0;
        end
        repeat (5) @(posedge clk_i);
        cs_b_o <= 1'b1;
        mosi_o <= ~mosi_o; // Released line shows the inverse of its last bit
        repeat (8) @(posedge clk_i);
    endtask
endmodule // sbcr_spi_master

// ===== verif/sbc_mode_supply_control_regs_bench.sv
// Self-checking bench of the mode/supply register bank.
// Assumes the master model in sbcr_spi_master and a 200 MHz clock.
`timescale 1ns/1ps
module sbc_mode_supply_control_regs_bench;
    logic clk_i = 1'b0, rst_b_i = 1'b0, noise = 1'b0;
    logic cs_b, sck, mosi, miso, miso_oe, miso_w;
    logic restart, otemp, ov, fail_act, uv;
    logic srst, ro_low, fo, ov_flag, ov_req, reg3, reg2, ls;
    sbcr_pkg::sbcr_dev_mode_e dmode;
    sbcr_pkg::sbcr_msc_s msc;
    sbcr_pkg::sbcr_hwc_s hwc;
    int fail_count = 0, samples_checked = 0, srst_n = 0, ro_n = 0;
    logic [7:0] msc_m, hwc_m, q, d;

    always #2.5 clk_i = ~clk_i;
    // Undriven miso wire toggles so a stale bit never passes
    always @(posedge clk_i) noise <= ~noise;
    assign miso_w = miso_oe ? miso : noise;
    // Count one-cycle pulses as they stand
    always @(posedge clk_i) begin
        if (srst === 1'b1) srst_n++;
        if (ro_low === 1'b1) ro_n++;
    end

    sbcr_spi_master partner_u (.clk_i(clk_i), .miso_i(miso_w),
        .cs_b_o(cs_b), .sck_o(sck), .mosi_o(mosi));

    sbcr_regs dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .spi_cs_b_i(cs_b),
        .spi_sck_i(sck), .spi_mosi_i(mosi), .spi_miso_o(miso),
        .spi_miso_oe_o(miso_oe), .device_mode_i(dmode),
        .restart_entry_i(restart), .overtemp_i(otemp), .main_ov_i(ov),
        .failure_active_i(fail_act), .supply_uv_i(uv), .msc_o(msc),
        .hwc_o(hwc), .soft_reset_o(srst), .reset_output_pin_low_o(ro_low),
        .failure_output_pins_o(fo), .main_ov_flag_o(ov_flag),
        .main_ov_mode_req_o(ov_req), .third_regulator_on_o(reg3),
        .second_regulator_on_o(reg2), .load_share_on_o(ls));

    // A sleep request from stop keeps the old mode field
    function automatic logic [7:0] msc_after(logic [7:0] o, logic [7:0] v,
                                             sbcr_pkg::sbcr_dev_mode_e m);
        if (v[7:6] == 2'h1 && m == sbcr_pkg::SBCR_DEV_STOP) v[7:6] = o[7:6];
        return v;
    endfunction

    function automatic logic exp_reg2(logic [1:0] p,
                                      sbcr_pkg::sbcr_dev_mode_e m);
        case (p)
            2'h0: return 1'b0;
            2'h1: return m == sbcr_pkg::SBCR_DEV_NORMAL;
            2'h2: return m == sbcr_pkg::SBCR_DEV_NORMAL ||
                         m == sbcr_pkg::SBCR_DEV_STOP;
            default: return m != sbcr_pkg::SBCR_DEV_FAILSAFE;
        endcase
    endfunction

    task automatic check(input string name, input logic [7:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, seen);
            fail_count++;
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        partner_u.xfer(a, 1'b1, v, 16, q);
    endtask

    task automatic rd(input logic [6:0] a);
        partner_u.xfer(a, 1'b0, 8'h00, 16, q);
    endtask

    // One-cycle event pulse: restart when set, overheat otherwise
    task automatic pulse(input bit to_restart);
        @(posedge clk_i);
        if (to_restart) restart <= 1'b1;
        else otemp <= 1'b1;
        @(posedge clk_i);
        {restart, otemp} <= 2'h0;
        repeat (2) @(posedge clk_i);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Hang guard: whole run is far below this count
    initial begin
        repeat (100000) @(posedge clk_i);
        fail_count++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        {restart, otemp, ov, fail_act, uv} = 5'h00;
        dmode = sbcr_pkg::SBCR_DEV_NORMAL;
        void'($urandom(32'ha4b6));
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        check("msc reset", msc, 8'h00);
        check("hwc reset", hwc, 8'h00);
        check("oe idle", miso_oe, 8'h00);
        msc_m = 8'h00;
        hwc_m = 8'h00;
        // Random writes, with device state and pins changing around them
        for (int k = 0; k < 12; k++) begin
            dmode <= sbcr_pkg::sbcr_dev_mode_e'($urandom % 4);
            {uv, ov} <= 2'($urandom);
            d = 8'($urandom);
            if (d[7:6] == 2'h3) d[7:6] = 2'h2; // No soft reset here
            wr(sbcr_pkg::SBCR_ADDR_MSC, d);
            check("msc old", q, msc_m);
            msc_m = msc_after(msc_m, d, dmode);
            d = 8'($urandom) & sbcr_pkg::SBCR_HWC_WMASK;
            wr(sbcr_pkg::SBCR_ADDR_HWC, d);
            check("hwc old", q, hwc_m);
            hwc_m = d;
            rd(sbcr_pkg::SBCR_ADDR_MSC);
            check("msc read", q, msc_m);
            rd(sbcr_pkg::SBCR_ADDR_HWC);
            check("hwc read", q, hwc_m);
            check("msc", msc, msc_m);
            check("hwc", hwc, hwc_m);
            check("reg2", reg2, exp_reg2(msc_m[4:3], dmode));
            check("reg3", reg3,
                  msc_m[5] & (~uv | hwc_m[4]));
            check("ls", ls, hwc_m[3] &
                  (dmode != sbcr_pkg::SBCR_DEV_STOP | hwc_m[1]));
            check("ov", {ov_req, ov_flag}, {ov & msc_m[2], ov});
            check("fo", fo, hwc_m[5]);
        end
        // Stop to sleep is refused, rest of byte is written
        dmode <= sbcr_pkg::SBCR_DEV_STOP;
        wr(sbcr_pkg::SBCR_ADDR_MSC, 8'h80);
        wr(sbcr_pkg::SBCR_ADDR_MSC, 8'h41);
        check("stop sleep", msc, 8'h81);
        // Short frame does nothing
        partner_u.xfer(sbcr_pkg::SBCR_ADDR_MSC, 1'b1, 8'h00, 8, q);
        check("short frame", msc, 8'h81);
        // Reserved bit and unmapped address
        wr(sbcr_pkg::SBCR_ADDR_HWC, 8'hff);
        rd(sbcr_pkg::SBCR_ADDR_HWC);
        check("reserved", q, 8'hfb);
        wr(7'h05, 8'hff);
        rd(7'h05);
        check("unmapped", q, 8'h00);
        // Failure holds the outputs after the software bit clears
        fail_act <= 1'b1;
        wr(sbcr_pkg::SBCR_ADDR_HWC, 8'hdb);
        check("fo held", fo, 8'h01);
        fail_act <= 1'b0;
        repeat (3) @(posedge clk_i);
        check("fo drop", fo, 8'h00);
        // Overtemperature turns regulator 2 policy off
        wr(sbcr_pkg::SBCR_ADDR_MSC, 8'h98);
        pulse(1'b0);
        check("overtemp", msc, 8'h80);
        // Restart masks both registers
        wr(sbcr_pkg::SBCR_ADDR_HWC, 8'hfb);
        wr(sbcr_pkg::SBCR_ADDR_MSC, 8'hbf);
        pulse(1'b1);
        check("restart msc", msc, 8'h23);
        check("restart hwc", hwc, 8'hd9);
        // Soft reset, with and without the reset output pulse
        for (int s = 0; s < 2; s++) begin
            d = 8'h9b | 8'(s << 6);
            wr(sbcr_pkg::SBCR_ADDR_HWC, d);
            srst_n = 0;
            ro_n = 0;
            wr(sbcr_pkg::SBCR_ADDR_MSC, 8'hc0);
            check("soft pulse", 8'(srst_n), 8'h01);
            check("ro pulse", 8'(ro_n), 8'(1 - s));
            check("soft msc", msc, 8'h00);
            check("soft hwc", hwc, d & 8'h88);
        end
        report_and_stop();
    end
endmodule // sbc_mode_supply_control_regs_bench
